// file: logic/atc_top.sv
// Activation throttle control: APB registers, per-branch global throttle flag and level selection.
// Assumes activate strobes and temperature reports arrive synchronous to pclk.
// Functional notes
// - Activates are counted per DIMM pair on each branch.
// - Count above global limit in a window sets branch flag and applies mid limit.
// - Each global limit unit means 65536 activates in the long window.
// - Global limit writes above 168 are stored as 168.
// - A zero global limit disables open-loop throttling in both window modes.
// - The long global window lasts 16384 times 1344 cycles.
// - The short window lasts 4 times 1344 cycles; a unit is 16 activates.
// - Flag clears after 16 quiet windows in a row, or 2 in short mode.
// - Each branch shows an 8-bit current level; 4 activates per step.
// - The current level is updated by hardware from the active condition.
// - Closed loop, cool and flag clear applies the low limit.
// - Open-loop mode applies the low limit as base level.
// - Mid limit applies for warm temperature in closed loop or with flag set.
// - Closed loop with hot temperature applies the high limit.
// - Low, mid, high limits are 8 bits, zero unlimited, clamped to 168.
// - Control bit 0 picks activation-count or temperature based level.
// - Each branch has a 16-bit status: flag bit 8, bits 15:9 zero.
`timescale 1ns/100ps
`include "atc_defs.svh"
module atc_top #(
	parameter int PAIRS     = 2,
	parameter int PAIR_W    = 1,
	parameter int RANKS     = 8,
	parameter int RANK_W    = 3,
	parameter int WIN_LONG  = `ATC_GTW_LONG_MUL * `ATC_GTW_UNIT,
	parameter int WIN_SHORT = `ATC_GTW_SHRT_MUL * `ATC_GTW_UNIT,
	parameter int ACT_WIN   = `ATC_ACT_WIN
) (
	// Clock and reset.
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave.
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic                             pready,
	output logic [31:0]                      prdata,
	output logic                             pslverr,
	// Activate strobes from the scheduler, one per branch.
	input  wire logic [1:0]                  act_issue,
	input  wire logic [1:0][RANK_W-1:0]      act_rank,
	// Temperature reports from the module buffer, one per branch.
	input  wire logic [1:0]                  temp_update,
	input  wire logic [1:0][1:0]             temp_zone,
	// Throttle results per branch.
	output logic [1:0][RANKS-1:0]            act_block,
	output logic [1:0][7:0]                  throttle_level,
	output logic [1:0]                       global_throttle
);
	// Configuration registers.
	logic [7:0] gbl_limit_r;
	logic [7:0] low_limit_r;
	logic [7:0] mid_limit_r;
	logic [7:0] high_limit_r;
	logic       select_r;
	logic       mode_r;
	logic       short_r;

	// Address decode: one aligned word per register, byte address four times the index.
	wire        setup_w    = psel && !penable && !pready;
	wire        wr_take    = psel && penable && pready && pwrite && !pslverr;
	wire [9:0]  word_w     = paddr[11:2];
	wire        hit_global = (word_w == {2'b00, `ATC_IDX_GLOBAL});
	wire        hit_low    = (word_w == {2'b00, `ATC_IDX_LOW});
	wire        hit_mid    = (word_w == {2'b00, `ATC_IDX_MID});
	wire        hit_high   = (word_w == {2'b00, `ATC_IDX_HIGH});
	wire        hit_ctrl   = (word_w == {2'b00, `ATC_IDX_CTRL});
	wire        hit_sts0   = (word_w == {2'b00, `ATC_IDX_STS0});
	wire        hit_sts1   = (word_w == {2'b00, `ATC_IDX_STS1});
	wire        hit_winsel = (word_w == {2'b00, `ATC_IDX_WINSEL});
	wire        hit_any    = hit_global | hit_low | hit_mid | hit_high | hit_ctrl |
	                         hit_sts0 | hit_sts1 | hit_winsel;
	// Status registers are read-only; a write to them is refused.
	wire        bad_w      = !hit_any || (pwrite && (hit_sts0 || hit_sts1));

	// Writes above the largest value are clamped before storage.
	wire [7:0]  wr_byte    = pwdata[7:0];
	wire [7:0]  wr_clamped = (wr_byte > `ATC_LIMIT_MAX) ? `ATC_LIMIT_MAX : wr_byte;

	// Per-branch state.
	logic [4:0] quiet_r [2];
	logic [1:0] zone_r  [2];
	logic [1:0] over_now;
	logic [1:0] win_end;
	logic [1:0] win_over;
	logic [1:0] flag_set;
	logic [1:0] flag_clr;
	logic [7:0] level_nxt [2];
	logic [15:0] sts_word [2];
	atc_pkg::atc_lvl_t lvl_sel [2];

	// Number of quiet windows that ends open-loop throttling.
	wire  [4:0] hold_w = short_r ? `ATC_HOLD_SHORT : `ATC_HOLD_LONG;

	// Read mux; narrow registers sit in the low bits, upper bits read zero.
	wire [31:0] rd_w =
		hit_global ? {24'h000000, gbl_limit_r} :
		hit_low    ? {24'h000000, low_limit_r} :
		hit_mid    ? {24'h000000, mid_limit_r} :
		hit_high   ? {24'h000000, high_limit_r} :
		hit_ctrl   ? {24'h000000, 6'h00, mode_r, select_r} :
		hit_sts0   ? {16'h0000, sts_word[0]} :
		hit_sts1   ? {16'h0000, sts_word[1]} :
		hit_winsel ? {31'h00000000, short_r} :
		32'h00000000;

	// APB answer: zero wait states, data and error captured in the setup cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup_w;
			prdata  <= setup_w ? rd_w : 32'h00000000;
			pslverr <= setup_w & bad_w;
		end
	end

	// Software-written configuration; each takes effect at the access edge.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gbl_limit_r  <= `ATC_RST_LIMIT;
			low_limit_r  <= `ATC_RST_LIMIT;
			mid_limit_r  <= `ATC_RST_LIMIT;
			high_limit_r <= `ATC_RST_LIMIT;
			select_r     <= 1'b0;
			mode_r       <= 1'b0;
			short_r      <= 1'b0;
		end
		else if (wr_take)
		begin
			if (hit_global)
				gbl_limit_r <= wr_clamped;
			else if (hit_low)
				low_limit_r <= wr_clamped;
			else if (hit_mid)
				mid_limit_r <= wr_clamped;
			else if (hit_high)
				high_limit_r <= wr_clamped;
			else if (hit_ctrl)
			begin
				select_r <= pwdata[`ATC_CTRL_SELECT];
				mode_r   <= pwdata[`ATC_CTRL_MODE];
			end
			else if (hit_winsel)
				short_r <= pwdata[`ATC_WINSEL_SHORT];
		end
	end

	// Branch logic: global window monitor, flag, level choice and activate gate.
	for (genvar b = 0; b < 2; b++)
	begin : g_branch
		atc_win_mon #(
			.PAIRS     (PAIRS),
			.PAIR_W    (PAIR_W),
			.WIN_LONG  (WIN_LONG),
			.WIN_SHORT (WIN_SHORT)
		) u_win (
			.pclk      (pclk),
			.presetn   (presetn),
			.short_sel (short_r),
			.limit     (gbl_limit_r),
			.act_issue (act_issue[b]),
			.act_pair  (act_rank[b][RANK_W-1 -: PAIR_W]),
			.over_now  (over_now[b]),
			.win_end   (win_end[b]),
			.win_over  (win_over[b])
		);

		// The flag sets on any excess; a quiet run of windows clears it, and a set wins over a clear.
		wire [4:0] quiet_inc = quiet_r[b] + 5'h01;
		assign flag_set[b] = over_now[b];
		assign flag_clr[b] = global_throttle[b] && win_end[b] && !win_over[b] && (quiet_inc >= hold_w);

		// Level selection: hot beats warm or flag, which beat the low base level.
		always_comb
		begin
			lvl_sel[b] = atc_pkg::ATC_LVL_LOW;
			if (select_r && (zone_r[b] == atc_pkg::ATC_ZONE_HOT))
				lvl_sel[b] = atc_pkg::ATC_LVL_HIGH;
			else if (global_throttle[b] || (select_r && (zone_r[b] == atc_pkg::ATC_ZONE_WARM)))
				lvl_sel[b] = atc_pkg::ATC_LVL_MID;
		end

		// Limit value for the chosen level.
		always_comb
		begin
			case (lvl_sel[b])
				atc_pkg::ATC_LVL_HIGH: level_nxt[b] = high_limit_r;
				atc_pkg::ATC_LVL_MID:  level_nxt[b] = mid_limit_r;
				default:               level_nxt[b] = low_limit_r;
			endcase
		end

		// Status word: level low byte, flag at bit 8, reserved bits zero.
		assign sts_word[b] = {7'h00, global_throttle[b], throttle_level[b]};

		// Flag, quiet-window count, latched temperature zone and current level.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				global_throttle[b] <= 1'b0;
				quiet_r[b]         <= 5'h00;
				zone_r[b]          <= atc_pkg::ATC_ZONE_COOL;
				throttle_level[b]  <= 8'h00;
			end
			else
			begin
				global_throttle[b] <= flag_set[b] | (global_throttle[b] & ~flag_clr[b]);
				if (flag_set[b] || flag_clr[b] || (win_end[b] && win_over[b]))
					quiet_r[b] <= 5'h00;
				else if (win_end[b] && global_throttle[b])
					quiet_r[b] <= quiet_inc;
				if (temp_update[b])
					zone_r[b] <= temp_zone[b];
				throttle_level[b] <= level_nxt[b];
			end
		end

		atc_act_gate #(
			.RANKS     (RANKS),
			.RANK_W    (RANK_W),
			.ACT_WIN   (ACT_WIN)
		) u_gate (
			.pclk      (pclk),
			.presetn   (presetn),
			.level     (throttle_level[b]),
			.act_issue (act_issue[b]),
			.act_rank  (act_rank[b]),
			.act_block (act_block[b])
		);
	end
endmodule

// file: logic/atc_defs.svh
// Register indices, field positions, reset values and timing counts for the activation throttle.
// Assumes a 32-bit APB slave with one word per register at byte address four times the index.
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH
// Register indices; byte address is the index times four.
`define ATC_IDX_GLOBAL   8'h60
`define ATC_IDX_LOW      8'h64
`define ATC_IDX_MID      8'h65
`define ATC_IDX_HIGH     8'h66
`define ATC_IDX_CTRL     8'h67
`define ATC_IDX_STS0     8'h68
`define ATC_IDX_STS1     8'h6a
`define ATC_IDX_WINSEL   8'h6c
// Field positions.
`define ATC_CTRL_SELECT  0
`define ATC_CTRL_MODE    1
`define ATC_STS_FLAG     8
`define ATC_WINSEL_SHORT 0
// Reset values.
`define ATC_RST_LIMIT    8'h00
`define ATC_RST_CTRL     2'h0
// Largest limit value; writes above it are clamped.
`define ATC_LIMIT_MAX    8'ha8
// Windows are given directly in core clock cycles.
`define ATC_GTW_UNIT     1344
`define ATC_GTW_LONG_MUL 16384
`define ATC_GTW_SHRT_MUL 4
`define ATC_HOLD_LONG    5'h10
`define ATC_HOLD_SHORT   5'h02
`define ATC_ACT_WIN      1344
`endif

// file: logic/atc_pkg.sv
// Types shared by the activation throttle modules.
// Assumes the constants header is included by each module that needs numbers.
package atc_pkg;
	// Which limit drives the current throttle level.
	typedef enum logic [2:0] {
		ATC_LVL_LOW  = 3'b001,
		ATC_LVL_MID  = 3'b010,
		ATC_LVL_HIGH = 3'b100
	} atc_lvl_t;
	// Temperature zone reported by the module buffer.
	typedef enum logic [1:0] {
		ATC_ZONE_COOL = 2'b00,
		ATC_ZONE_WARM = 2'b01,
		ATC_ZONE_HOT  = 2'b10
	} atc_zone_t;
endpackage

// file: logic/atc_win_mon.sv
// Global window monitor for one branch: counts activates per DIMM pair in each global window.
// Assumes activate strobes come from the scheduler on the same clock.
`timescale 1ns/100ps
`include "atc_defs.svh"
module atc_win_mon #(
	parameter int PAIRS     = 2,
	parameter int PAIR_W    = 1,
	parameter int WIN_LONG  = `ATC_GTW_LONG_MUL * `ATC_GTW_UNIT,
	parameter int WIN_SHORT = `ATC_GTW_SHRT_MUL * `ATC_GTW_UNIT
) (
	// Clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Configuration.
	input  wire logic              short_sel,
	input  wire logic [7:0]        limit,
	// Activate strobe.
	input  wire logic              act_issue,
	input  wire logic [PAIR_W-1:0] act_pair,
	// Results.
	output logic                   over_now,
	output logic                   win_end,
	output logic                   win_over
);
	logic [24:0]      timer_r;
	logic [24:0]      cnt_r [PAIRS];
	logic             seen_r;
	logic [PAIRS-1:0] over_w;
	wire  [24:0]      win_last = short_sel ? 25'(WIN_SHORT - 1) : 25'(WIN_LONG - 1);
	wire              end_w    = (timer_r >= win_last);
	// Each limit unit is 16 activates in the short window, 65536 in the long one.
	wire  [24:0]      thresh   = short_sel ? {13'h0000, limit, 4'h0} : {1'b0, limit, 16'h0000};
	wire              any_over = |over_w;

	// Per-pair counters restart with each window; a zero limit never trips.
	for (genvar p = 0; p < PAIRS; p++)
	begin : g_pair
		wire        inc_w = act_issue && (act_pair == PAIR_W'(p));
		wire [24:0] sum_w = cnt_r[p] + {24'h000000, inc_w};
		assign over_w[p] = (limit != 8'h00) && (sum_w > thresh);
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				cnt_r[p] <= 25'h0000000;
			else
				cnt_r[p] <= end_w ? 25'h0000000 : sum_w;
		end
	end

	// Window timer and the registered window results.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer_r  <= 25'h0000000;
			seen_r   <= 1'b0;
			over_now <= 1'b0;
			win_end  <= 1'b0;
			win_over <= 1'b0;
		end
		else
		begin
			timer_r  <= end_w ? 25'h0000000 : timer_r + 25'h0000001;
			seen_r   <= end_w ? 1'b0 : (seen_r | any_over);
			over_now <= any_over;
			win_end  <= end_w;
			win_over <= end_w & (seen_r | any_over);
		end
	end
endmodule

// file: logic/atc_act_gate.sv
// Per-rank activate gate for one branch: withholds activates once the level's budget is used.
// Assumes the scheduler honours act_block in the cycle after it rises.
`timescale 1ns/100ps
`include "atc_defs.svh"
module atc_act_gate #(
	parameter int RANKS   = 8,
	parameter int RANK_W  = 3,
	parameter int ACT_WIN = `ATC_ACT_WIN
) (
	// Clock and reset.
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Current throttle level.
	input  wire logic [7:0]        level,
	// Activate strobe.
	input  wire logic              act_issue,
	input  wire logic [RANK_W-1:0] act_rank,
	// Block mask per rank.
	output logic [RANKS-1:0]       act_block
);
	logic [12:0] timer_r;
	logic [9:0]  cnt_r [RANKS];
	wire         end_w = (timer_r >= 13'(ACT_WIN - 1));
	wire  [9:0]  cap_w = {level, 2'b00};

	// Activation window timer.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_r <= 13'h0000;
		else
			timer_r <= end_w ? 13'h0000 : timer_r + 13'h0001;
	end

	// Each rank counts its activates and blocks once four per level step are used.
	for (genvar r = 0; r < RANKS; r++)
	begin : g_rank
		wire       inc_w = act_issue && (act_rank == RANK_W'(r));
		wire [9:0] sum_w = (cnt_r[r] == 10'h3ff) ? cnt_r[r] : cnt_r[r] + {9'h000, inc_w};
		wire [9:0] nxt_w = end_w ? 10'h000 : sum_w;
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				cnt_r[r]     <= 10'h000;
				act_block[r] <= 1'b0;
			end
			else
			begin
				cnt_r[r]     <= nxt_w;
				act_block[r] <= (level != 8'h00) && (nxt_w >= cap_w);
			end
		end
	end
endmodule

// file: verification/atc_top_assertions.sv
// Checker for the activation throttle top: APB answer timing and throttle outputs.
// Assumes it is bound into atc_top and sees only that module's ports.
`timescale 1ns/100ps
module atc_top_chk #(
	parameter int RANKS  = 8,
	parameter int RANK_W = 3
) (
	// Clock and reset.
	input wire logic                   pclk,
	input wire logic                   presetn,
	// APB slave.
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic                   pready,
	input wire logic [31:0]            prdata,
	input wire logic                   pslverr,
	// Scheduler and temperature side.
	input wire logic [1:0]             act_issue,
	input wire logic [1:0][RANK_W-1:0] act_rank,
	input wire logic [1:0]             temp_update,
	input wire logic [1:0][1:0]        temp_zone,
	input wire logic [1:0][RANKS-1:0]  act_block,
	input wire logic [1:0][7:0]        throttle_level,
	input wire logic [1:0]             global_throttle
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// A setup cycle opens every transfer.
	wire setup = psel && !penable;
	property p_rdy_next; setup |=> pready; endproperty
	property p_rdy_one; pready |=> !pready; endproperty
	property p_err_qual; pslverr |-> pready; endproperty
	property p_sts_ro; setup && pwrite && (paddr[11:2] == 10'h068 || paddr[11:2] == 10'h06a) |=> pslverr; endproperty
	property p_unmapped; setup && !pwrite && paddr[11:2] == 10'h001 |=> pslverr && prdata == 32'h0; endproperty
	property p_lvl_max; throttle_level[0] <= 8'ha8 && throttle_level[1] <= 8'ha8; endproperty
	property p_flag_cause; $rose(global_throttle[1]) |-> $past(act_issue[1], 2); endproperty
	property p_blk_cause; (act_block[0] & ~$past(act_block[0])) != 0 |-> $past(act_issue[0]); endproperty
	a_rdy_next: assert property (p_rdy_next) else $error("no answer after setup");
	a_rdy_one: assert property (p_rdy_one) else $error("ready held too long");
	a_err_qual: assert property (p_err_qual) else $error("error without ready");
	a_sts_ro: assert property (p_sts_ro) else $error("status write accepted");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	a_lvl_max: assert property (p_lvl_max) else $error("level above full bandwidth");
	a_flag_cause: assert property (p_flag_cause) else $error("flag rose without activate");
	a_blk_cause: assert property (p_blk_cause) else $error("block rose without activate");
	// Main scenarios reached.
	c_write: cover property (setup && pwrite ##1 pready);
	c_flag_up: cover property ($rose(global_throttle[1]));
	c_flag_down: cover property ($fell(global_throttle[1]));
endmodule

bind atc_top atc_top_chk #(.RANKS(RANKS), .RANK_W(RANK_W)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .prdata, .pslverr, .act_issue, .act_rank, .temp_update, .temp_zone,
	.act_block, .throttle_level, .global_throttle);

// file: verification/atc_sched_model.sv
// Model of the command scheduler and module temperature reports for both branches.
// Assumes the bench clock; outputs change by non-blocking assignment after a rising edge.
`timescale 1ns/100ps
module atc_sched_model (
	// Clock.
	input  wire logic       pclk,
	// Block mask from the throttle.
	input  wire logic [1:0][7:0] act_block,
	// Activates and temperature reports.
	output logic [1:0]      act_issue,
	output logic [1:0][2:0] act_rank,
	output logic [1:0]      temp_update,
	output logic [1:0][1:0] temp_zone
);
	// Idle until the bench asks for traffic.
	initial
	begin
		act_issue = 2'h0;
		act_rank = 6'h00;
		temp_update = 2'h0;
		temp_zone = 4'h0;
	end
	// Issue n activates on branch b alternating r0 and r1; a blocked rank waits, so bursts may stretch.
	task burst(input int b, input logic [2:0] r0, input logic [2:0] r1, input int n);
		logic [2:0] r;
		int i;
		i = 0;
		while (i < n)
		begin
			r = i[0] ? r1 : r0;
			act_issue[b] <= !act_block[b][r];
			act_rank[b] <= r;
			if (!act_block[b][r])
				i++;
			@(posedge pclk);
		end
		act_issue[b] <= 1'b0;
	endtask
	// Report one temperature zone on both branches.
	task temp(input logic [1:0] z);
		temp_zone <= {z, z};
		temp_update <= 2'h3;
		@(posedge pclk);
		temp_update <= 2'h0;
	endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the activation throttle with shortened windows.
// Assumes the design files and the constants header are compiled first.
`timescale 1ns/100ps
`include "atc_defs.svh"
module tb_top;
	localparam logic [11:0] ADR [8] = '{{2'h0, `ATC_IDX_GLOBAL, 2'h0}, {2'h0, `ATC_IDX_LOW, 2'h0},
		{2'h0, `ATC_IDX_MID, 2'h0}, {2'h0, `ATC_IDX_HIGH, 2'h0}, {2'h0, `ATC_IDX_CTRL, 2'h0},
		{2'h0, `ATC_IDX_STS0, 2'h0}, {2'h0, `ATC_IDX_STS1, 2'h0}, {2'h0, `ATC_IDX_WINSEL, 2'h0}};
	localparam logic [7:0] VAL [4] = '{8'hff, 8'ha9, 8'ha8, 8'h07};
	localparam logic [7:0] LV [4] = '{8'h03, 8'h02, 8'h01, 8'h03};
	logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, seen_clr;
	logic [11:0]            paddr;
	logic [31:0]            pwdata, prdata;
	logic [1:0]             act_issue, temp_update, global_throttle;
	logic [1:0][2:0]        act_rank;
	logic [1:0][1:0]        temp_zone;
	logic [1:0][7:0]        act_block, throttle_level;
	logic [7:0]             blk_seen;
	int                     errors, tests_run;
	// Design with short windows so the run stays brief.
	atc_top #(.WIN_LONG(200), .WIN_SHORT(40), .ACT_WIN(20)) uut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pready, .prdata, .pslverr, .act_issue, .act_rank, .temp_update, .temp_zone,
		.act_block, .throttle_level, .global_throttle);
	atc_sched_model sched (.pclk, .act_block, .act_issue, .act_rank, .temp_update, .temp_zone);
	// Clock at 250 MHz.
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Remember every branch 0 rank that was blocked since seen_clr was last raised.
	always @(posedge pclk)
		blk_seen <= seen_clr ? 8'h00 : blk_seen | act_block[0];
	task chk(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; exp holds the error flag and read data.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		chk({pready, pslverr, w ? 32'h0 : prdata}, {1'b1, exp});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task rd(input logic [11:0] a, input logic [32:0] e);
		apb(1'b0, a, 32'h0, e);
	endtask
	task settle;
		repeat (3) @(posedge pclk);
	endtask
	task t_regs;
		foreach (ADR[k])
			rd(ADR[k], 33'h0);
		rd(12'h004, {1'b1, 32'h0});
		apb(1'b1, ADR[6], 32'h1ff, {1'b1, 32'h0});
		rd(ADR[6], 33'h0);
	endtask
	task t_clamp;
		for (int k = 0; k < 4; k++)
			for (int j = 0; j < 4; j++)
			begin
				wr(ADR[k], VAL[j]);
				rd(ADR[k], VAL[j] > 8'ha8 ? 8'ha8 : VAL[j]);
			end
		wr(ADR[4], 32'hff);
		rd(ADR[4], 33'h3);
	endtask
	task t_levels;
		wr(ADR[1], 3);
		wr(ADR[2], 2);
		wr(ADR[3], 1);
		wr(ADR[4], 0);
		settle;
		chk(throttle_level, 16'h0303);
		rd(ADR[5], 33'h3);
		wr(ADR[4], 3);
		for (int z = 0; z < 4; z++)
		begin
			sched.temp(z[1:0]);
			settle;
			chk(throttle_level, {2{LV[z]}});
		end
		sched.temp(2'h0);
		wr(ADR[4], 0);
	endtask
	task t_block(input logic [31:0] lvl, input logic [7:0] exp);
		wr(ADR[1], lvl);
		seen_clr <= 1'b1;
		@(posedge pclk);
		seen_clr <= 1'b0;
		sched.burst(0, 3'h2, 3'h2, 8);
		settle;
		chk(blk_seen, exp);
		repeat (22) @(posedge pclk);
		chk(act_block[0], 8'h00);
	endtask
	task t_global;
		int n;
		wr(ADR[1], 0);
		wr(ADR[7], 1);
		wr(ADR[0], 1);
		sched.burst(1, 3'h0, 3'h4, 30);
		settle;
		chk(global_throttle, 2'h0);
		sched.burst(1, 3'h0, 3'h0, 36);
		settle;
		chk(global_throttle, 2'h2);
		chk(throttle_level, 16'h0200);
		repeat (33) @(posedge pclk);
		chk(global_throttle, 2'h2);
		for (n = 0; n < 120 && global_throttle[1] !== 1'b0; n++)
			@(posedge pclk);
		settle;
		chk({global_throttle, throttle_level}, 18'h0);
		wr(ADR[0], 0);
		sched.burst(1, 3'h0, 3'h0, 36);
		settle;
		chk(global_throttle, 2'h0);
		chk(act_block, 16'h0000);
	endtask
	task final_report;
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Cut a hang short.
	initial
	begin
		repeat (4000) @(posedge pclk);
		errors++;
		final_report;
	end
	// Reset, then the scenarios in order.
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, seen_clr} = '0;
		presetn = 1'b0;
		errors = 0;
		tests_run = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_clamp;
		t_levels;
		t_block(1, 8'h04);
		t_block(0, 8'h00);
		t_global;
		final_report;
	end
endmodule
